// ### i2cm_bus_slave.sv
`timescale 1ns/10ps
module i2cm_bus_slave (
    // Clock and bus
    input  wire       mclk,
    input  wire       scl_oe,
    input  wire [3:0] stall_cyc,
    output wire       scl_wire
);
    reg [3:0] hold_ff = 4'h0;

    // Slow slave keeps SCL low after the master lets go
    always @(posedge mclk) begin
        if (scl_oe)
            hold_ff <= stall_cyc;
        else if (hold_ff != 4'h0)
            hold_ff <= hold_ff - 4'h1;
    end
    // Pull-up wins only when nobody pulls low
    assign scl_wire = !(scl_oe || hold_ff != 4'h0);
endmodule

// ### i2cm_defs.vh
`ifndef I2CM_DEFS_VH
`define I2CM_DEFS_VH

// ----------------------------------------
// Register indices (byte address = 4 * index)
// ----------------------------------------
`define I2CM_IDX_HIGH_CNT      6'h0A
`define I2CM_IDX_LOW_CNT       6'h0B
`define I2CM_IDX_PORT_CTL      6'h0C
`define I2CM_IDX_STATUS        6'h20
`define I2CM_ADDR_SHIFT        2
`define I2CM_ADDR_W            8

// ----------------------------------------
// Reset values
// ----------------------------------------
`define I2CM_RST_HIGH_CNT      8'h7A
`define I2CM_RST_LOW_CNT       8'h7A
`define I2CM_RST_PORT_CTL      8'h0F

// ----------------------------------------
// Port control fields
// ----------------------------------------
`define I2CM_MAP_LSB           4
`define I2CM_MAP_MSB           7
`define I2CM_EN_LSB            0
`define I2CM_EN_MSB            3
`define I2CM_NUM_CHAN          4

// ----------------------------------------
// Status fields
// ----------------------------------------
`define I2CM_ST_MST_LSB        0
`define I2CM_ST_MST_MSB        3
`define I2CM_ST_SLV_LSB        4
`define I2CM_ST_SLV_MSB        5
`define I2CM_ST_SCL_IN         6
`define I2CM_ST_REF            7

// ----------------------------------------
// Timing
// ----------------------------------------
`define I2CM_OSC_PERIOD_NS     40
`define I2CM_MCLK_PERIOD_NS    20
`define I2CM_MCLK_PER_OSC      (`I2CM_OSC_PERIOD_NS / `I2CM_MCLK_PERIOD_NS)
`define I2CM_EXTRA_OSC         9'h005
`define I2CM_CNT_W             9
`define I2CM_SUB_W             4

`endif

// ### i2cm_phase_timer.v
`timescale 1ns/10ps
`include "i2cm_defs.vh"

module i2cm_phase_timer (
    // Clock and reset
    input  wire                    mclk,
    input  wire                    rst_n,
    // Control
    input  wire                    load,
    input  wire [`I2CM_CNT_W-1:0]  load_val,
    // Status
    output wire                    busy,
    output wire                    done
);

    localparam integer           SUB_LAST_I = `I2CM_MCLK_PER_OSC - 1;
    localparam [`I2CM_SUB_W-1:0] SUB_LAST   = SUB_LAST_I[`I2CM_SUB_W-1:0];
    localparam [`I2CM_CNT_W-1:0] CNT_ONE  = 9'h001;
    localparam [`I2CM_CNT_W-1:0] CNT_ZERO = 9'h000;

    reg [`I2CM_CNT_W-1:0] cnt_ff;
    reg [`I2CM_SUB_W-1:0] sub_ff;
    reg                   done_ff;
    reg [`I2CM_CNT_W-1:0] nxt_cnt;
    reg [`I2CM_SUB_W-1:0] nxt_sub;
    reg                   nxt_done;

    // ----------------------------------------
    // Down-counter of oscillator periods
    // ----------------------------------------
    // Sub-divider restarts on load so every phase is exact, not jittered
    always @* begin
        nxt_cnt  = cnt_ff;
        nxt_sub  = sub_ff;
        nxt_done = 1'b0;
        if (load) begin
            nxt_cnt = load_val;
            nxt_sub = 4'h0;
        end else if (cnt_ff != CNT_ZERO) begin
            if (sub_ff == SUB_LAST) begin
                nxt_sub = 4'h0;
                nxt_cnt = cnt_ff - CNT_ONE;
            end else begin
                nxt_sub = sub_ff + 4'h1;
                // Done leads by one cycle: caller's state flop adds one back
                if ((cnt_ff == CNT_ONE) && (nxt_sub == SUB_LAST)) begin
                    nxt_done = 1'b1;
                end
            end
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            cnt_ff  <= 9'h000;
            sub_ff  <= 4'h0;
            done_ff <= 1'b0;
        end else begin
            cnt_ff  <= nxt_cnt;
            sub_ff  <= nxt_sub;
            done_ff <= nxt_done;
        end
    end

    assign busy = (cnt_ff != CNT_ZERO);
    assign done = done_ff;

endmodule

// ### i2cm_props.sv
`timescale 1ns/10ps
module i2cm_props (
    // Clock, reset and APB
    input wire        mclk,
    input wire        rstn,
    input wire        psel,
    input wire        penable,
    input wire        pwrite,
    input wire [7:0]  paddr,
    input wire [31:0] pwdata,
    input wire        pready,
    input wire [31:0] prdata,
    input wire        pslverr,
    // SCL master and slave setup
    input wire        mst_clk_req,
    input wire        scl_in,
    input wire        scl_out,
    input wire        scl_oe,
    input wire        scl_fall,
    input wire        scl_rise,
    input wire        slv_stretch,
    input wire        slv_sda_valid,
    input wire        slv_setup_done,
    // Routing and receiver ports
    input wire [3:0]  chan_req,
    input wire [3:0]  chan_to_slave0,
    input wire [3:0]  chan_to_slave1,
    input wire        reference_clock_input,
    input wire        rx_port0_on,
    input wire        rx_port1_on,
    input wire        rx_port2_on,
    input wire        rx_port3_on
);
    // ----------------------------------------
    // Shadow registers and phase counters
    // ----------------------------------------
    reg  [7:0]  hi_ff;
    reg  [7:0]  lo_ff;
    reg  [7:0]  ctl_ff;
    reg  [11:0] oe_cnt_ff;
    reg  [11:0] hc_ff;
    reg         rise_seen_ff;
    wire        wr     = psel && penable && pwrite && pready;
    wire [11:0] lo_len = {3'h0, lo_ff, 1'b0} + 12'h00A;
    wire [11:0] hi_len = {3'h0, hi_ff, 1'b0} + 12'h00A;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            hi_ff        <= 8'h7A;
            lo_ff        <= 8'h7A;
            ctl_ff       <= 8'h0F;
            oe_cnt_ff    <= 12'h000;
            hc_ff        <= 12'h000;
            rise_seen_ff <= 1'b0;
        end else begin
            if (wr && paddr == 8'h28)
                hi_ff <= pwdata[7:0];
            if (wr && paddr == 8'h2C)
                lo_ff <= pwdata[7:0];
            if (wr && paddr == 8'h30)
                ctl_ff <= pwdata[7:0];
            oe_cnt_ff    <= scl_oe ? oe_cnt_ff + 12'h001 : 12'h000;
            hc_ff        <= (scl_in && !scl_oe) ? hc_ff + 12'h001 : 12'h000;
            rise_seen_ff <= mst_clk_req && (scl_rise || (rise_seen_ff && !scl_oe));
        end
    end

    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rstn);

    sequence s_mst_low_start;
        $rose(scl_oe) && mst_clk_req && !slv_stretch;
    endsequence
    // Stretch may act one cycle late, so two cycles are excluded
    sequence s_phase_end;
        $fell(scl_oe) && !$past(slv_stretch) && !$past(slv_stretch, 2);
    endsequence

    AST_FALL_PULSE: assert property (s_mst_low_start |-> scl_fall && !scl_rise)
        else $error("no fall pulse after master low start");
    AST_LOW_LEN: assert property (s_phase_end |-> oe_cnt_ff == lo_len)
        else $error("low phase length wrong");
    AST_HIGH_LEN: assert property ($rose(scl_oe) && rise_seen_ff |->
        hc_ff >= hi_len && hc_ff <= hi_len + 12'h003)
        else $error("high phase length wrong");
    AST_RISE_WIRE: assert property (scl_rise |-> !scl_oe && scl_in && $past(scl_in))
        else $error("rise pulse without released line");
    AST_SLV_START: assert property (slv_sda_valid && !scl_oe && !mst_clk_req |=> scl_oe)
        else $error("slave setup did not hold line");
    AST_SETUP_DONE: assert property (slv_setup_done |-> !scl_oe && $past(scl_oe))
        else $error("setup done at wrong time");
    AST_SCL_DATA: assert property (scl_out == 1'b0)
        else $error("clock data line not held at zero");
    AST_STRETCH: assert property (slv_stretch [*3] |-> scl_oe)
        else $error("stretch not holding line");
    AST_ROUTE: assert property (1'b1 |=> chan_to_slave0 == $past(chan_req & ~ctl_ff[7:4])
        && chan_to_slave1 == $past(chan_req & ctl_ff[7:4]))
        else $error("channel routing wrong");
    AST_PORT_EN: assert property ({rx_port3_on, rx_port2_on, rx_port1_on, rx_port0_on}
        == ctl_ff[3:0])
        else $error("receiver enables differ from register");
    AST_SLVERR: assert property (psel && penable && (pwrite ? !(paddr inside {8'h28, 8'h2C,
        8'h30}) : !(paddr inside {8'h28, 8'h2C, 8'h30, 8'h80})) |-> pslverr)
        else $error("bad access not refused");
endmodule

// ### i2cm_top.v
// Register access over APB is this design's own decision.
`timescale 1ns/10ps
`include "i2cm_defs.vh"

module i2cm_top (
    // Clock and reset
    input  wire        mclk,
    input  wire        rstn,
    // APB slave
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [7:0]  paddr,
    input  wire [31:0] pwdata,
    output wire        pready,
    output wire [31:0] prdata,
    output wire        pslverr,
    // Local I2C master clocking
    input  wire        mst_clk_req,
    input  wire        scl_in,
    output wire        scl_out,
    output wire        scl_oe,
    output wire        scl_fall,
    output wire        scl_rise,
    // Control channel slave access
    input  wire        slv_stretch,
    input  wire        slv_sda_valid,
    output wire        slv_setup_done,
    // Control channel routing
    input  wire [3:0]  chan_req,
    output wire [3:0]  chan_to_slave0,
    output wire [3:0]  chan_to_slave1,
    // Receiver ports and clock source
    input  wire        reference_clock_input,
    output wire        rx_port0_on,
    output wire        rx_port1_on,
    output wire        rx_port2_on,
    output wire        rx_port3_on
);

    // ----------------------------------------
    // States
    // ----------------------------------------
    localparam [3:0] M_IDLE  = 4'h1;
    localparam [3:0] M_LOW   = 4'h2;
    localparam [3:0] M_RWAIT = 4'h4;
    localparam [3:0] M_HIGH  = 4'h8;
    localparam [1:0] S_IDLE  = 2'h1;
    localparam [1:0] S_SETUP = 2'h2;

    // ----------------------------------------
    // Reset synchroniser
    // ----------------------------------------
    reg rst_meta_ff;
    reg rst_sync_ff;

    always @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    wire rst_n = rst_sync_ff;

    // ----------------------------------------
    // Registers
    // ----------------------------------------
    reg [7:0]  high_cnt_ff;
    reg [7:0]  low_cnt_ff;
    reg [7:0]  port_ctl_ff;
    reg [31:0] prdata_ff;
    reg        pslverr_ff;
    reg [3:0]  mst_state_ff;
    reg [3:0]  nxt_mst_state;
    reg [1:0]  slv_state_ff;
    reg [1:0]  nxt_slv_state;
    reg        scl_fall_ff;
    reg        scl_rise_ff;
    reg        slv_done_ff;
    reg [3:0]  to_slave0_ff;
    reg [3:0]  to_slave1_ff;

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire       apb_setup  = psel & ~penable;
    wire       apb_access = psel & penable;
    wire [5:0] reg_idx    = paddr[7:`I2CM_ADDR_SHIFT];
    wire       aligned    = (paddr[1:0] == 2'h0);
    wire       hit_high   = aligned & (reg_idx == `I2CM_IDX_HIGH_CNT);
    wire       hit_low    = aligned & (reg_idx == `I2CM_IDX_LOW_CNT);
    wire       hit_ctl    = aligned & (reg_idx == `I2CM_IDX_PORT_CTL);
    wire       hit_stat   = aligned & (reg_idx == `I2CM_IDX_STATUS);
    wire       hit_any    = hit_high | hit_low | hit_ctl | hit_stat;
    wire       bad_acc    = ~hit_any | (pwrite & hit_stat);
    wire       wr_ok      = apb_access & pwrite & ~bad_acc;

    // Zero wait states keep the master simple
    assign pready  = 1'b1;
    assign prdata  = prdata_ff;
    assign pslverr = pslverr_ff;

    // ----------------------------------------
    // Status word
    // ----------------------------------------
    wire [7:0] status_word;

    assign status_word[`I2CM_ST_MST_MSB:`I2CM_ST_MST_LSB] = mst_state_ff;
    assign status_word[`I2CM_ST_SLV_MSB:`I2CM_ST_SLV_LSB] = slv_state_ff;
    assign status_word[`I2CM_ST_SCL_IN]                   = scl_in;
    assign status_word[`I2CM_ST_REF]                      = reference_clock_input;

    reg [7:0] rd_mux;

    always @* begin
        rd_mux = 8'h00;
        if (hit_high) begin
            rd_mux = high_cnt_ff;
        end else if (hit_low) begin
            rd_mux = low_cnt_ff;
        end else if (hit_ctl) begin
            rd_mux = port_ctl_ff;
        end else if (hit_stat) begin
            rd_mux = status_word;
        end
    end

    // Read data is captured in setup so it stands through access
    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            prdata_ff  <= 32'h00000000;
            pslverr_ff <= 1'b0;
        end else if (apb_setup) begin
            prdata_ff  <= {24'h000000, rd_mux};
            pslverr_ff <= bad_acc;
        end else if (!psel) begin
            pslverr_ff <= 1'b0;
        end
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            high_cnt_ff <= `I2CM_RST_HIGH_CNT;
            low_cnt_ff  <= `I2CM_RST_LOW_CNT;
            port_ctl_ff <= `I2CM_RST_PORT_CTL;
        end else if (wr_ok) begin
            if (hit_high) begin
                high_cnt_ff <= pwdata[7:0];
            end
            if (hit_low) begin
                low_cnt_ff <= pwdata[7:0];
            end
            if (hit_ctl) begin
                port_ctl_ff <= pwdata[7:0];
            end
        end
    end

    // ----------------------------------------
    // Phase lengths
    // ----------------------------------------
    // Five extra oscillator periods are added in every phase
    wire [8:0] high_len = {1'b0, high_cnt_ff} + `I2CM_EXTRA_OSC;
    wire [8:0] low_len  = {1'b0, low_cnt_ff} + `I2CM_EXTRA_OSC;

    // ----------------------------------------
    // Master SCL generator
    // ----------------------------------------
    reg        mst_load;
    reg [8:0]  mst_val;
    wire       mst_busy;
    wire       mst_done;

    i2cm_phase_timer u_mst_timer (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .load     (mst_load),
        .load_val (mst_val),
        .busy     (mst_busy),
        .done     (mst_done)
    );

    always @* begin
        nxt_mst_state = mst_state_ff;
        mst_load      = 1'b0;
        mst_val       = low_len;
        case (mst_state_ff)
            M_IDLE: begin
                if (mst_clk_req) begin
                    nxt_mst_state = M_LOW;
                    mst_load      = 1'b1;
                    mst_val       = low_len;
                end
            end
            M_LOW: begin
                if (mst_done) begin
                    nxt_mst_state = M_RWAIT;
                end
            end
            M_RWAIT: begin
                // A slave stretching SCL delays the high count start
                if (scl_in) begin
                    nxt_mst_state = M_HIGH;
                    mst_load      = 1'b1;
                    mst_val       = high_len;
                end
            end
            M_HIGH: begin
                if (mst_done) begin
                    if (mst_clk_req) begin
                        nxt_mst_state = M_LOW;
                        mst_load      = 1'b1;
                        mst_val       = low_len;
                    end else begin
                        nxt_mst_state = M_IDLE;
                    end
                end
            end
            default: begin
                nxt_mst_state = M_IDLE;
            end
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            mst_state_ff <= M_IDLE;
            scl_fall_ff  <= 1'b0;
            scl_rise_ff  <= 1'b0;
        end else begin
            mst_state_ff <= nxt_mst_state;
            scl_fall_ff  <= (nxt_mst_state == M_LOW) & (mst_state_ff != M_LOW);
            scl_rise_ff  <= (nxt_mst_state == M_HIGH) & (mst_state_ff != M_HIGH);
        end
    end

    assign scl_fall = scl_fall_ff;
    assign scl_rise = scl_rise_ff;

    // ----------------------------------------
    // Slave SDA setup before SCL release
    // ----------------------------------------
    wire slv_busy;
    wire slv_done;
    wire slv_load = (slv_state_ff == S_IDLE) & slv_sda_valid;

    i2cm_phase_timer u_slv_timer (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .load     (slv_load),
        .load_val (low_len),
        .busy     (slv_busy),
        .done     (slv_done)
    );

    always @* begin
        nxt_slv_state = slv_state_ff;
        case (slv_state_ff)
            S_IDLE: begin
                if (slv_sda_valid) begin
                    nxt_slv_state = S_SETUP;
                end
            end
            S_SETUP: begin
                if (slv_done) begin
                    nxt_slv_state = S_IDLE;
                end
            end
            default: begin
                nxt_slv_state = S_IDLE;
            end
        endcase
    end

    always @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            slv_state_ff <= S_IDLE;
            slv_done_ff  <= 1'b0;
        end else begin
            slv_state_ff <= nxt_slv_state;
            slv_done_ff  <= slv_done;
        end
    end

    assign slv_setup_done = slv_done_ff;

    // ----------------------------------------
    // SCL pin
    // ----------------------------------------
    // Open drain: enable pulls low, data line is always zero
    wire slv_hold = slv_stretch | (slv_state_ff == S_SETUP);

    assign scl_oe  = (mst_state_ff == M_LOW) | slv_hold;
    assign scl_out = 1'b0;

    // ----------------------------------------
    // Control channel routing
    // ----------------------------------------
    genvar ch;
    generate
        for (ch = 0; ch < `I2CM_NUM_CHAN; ch = ch + 1) begin : g_chan
            always @(posedge mclk or negedge rst_n) begin
                if (!rst_n) begin
                    to_slave0_ff[ch] <= 1'b0;
                    to_slave1_ff[ch] <= 1'b0;
                end else begin
                    to_slave0_ff[ch] <= chan_req[ch] & ~port_ctl_ff[`I2CM_MAP_LSB + ch];
                    to_slave1_ff[ch] <= chan_req[ch] & port_ctl_ff[`I2CM_MAP_LSB + ch];
                end
            end
        end
    endgenerate

    assign chan_to_slave0 = to_slave0_ff;
    assign chan_to_slave1 = to_slave1_ff;

    // ----------------------------------------
    // Receiver enables
    // ----------------------------------------
    assign rx_port0_on = port_ctl_ff[`I2CM_EN_LSB];
    assign rx_port1_on = port_ctl_ff[`I2CM_EN_LSB + 1];
    assign rx_port2_on = port_ctl_ff[`I2CM_EN_LSB + 2];
    assign rx_port3_on = port_ctl_ff[`I2CM_EN_MSB];

endmodule

// ### tb_top.sv
`timescale 1ns/10ps
module tb_top;
    reg         mclk;
    reg         rstn;
    reg         psel;
    reg         penable;
    reg         pwrite;
    reg  [7:0]  paddr;
    reg  [31:0] pwdata;
    reg         mst_clk_req;
    reg         slv_stretch;
    reg         slv_sda_valid;
    reg         ref_in;
    reg  [3:0]  chan_req;
    reg  [3:0]  stall_cyc;
    reg  [7:0]  ctl;
    wire        pready;
    wire        pslverr;
    wire [31:0] prdata;
    wire        scl_in;
    wire        scl_oe;
    wire        scl_fall;
    wire        scl_rise;
    wire        setup_done;
    wire [3:0]  c0;
    wire [3:0]  c1;
    wire [3:0]  rx_on;
    reg  [33:0] expq[$];
    integer     n_errors;
    integer     n_tests;
    integer     seed;
    integer     cyc;
    integer     i;

    i2cm_top dut (.mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
        .prdata(prdata), .pslverr(pslverr), .mst_clk_req(mst_clk_req),
        .scl_in(scl_in), .scl_out(), .scl_oe(scl_oe), .scl_fall(scl_fall),
        .scl_rise(scl_rise), .slv_stretch(slv_stretch), .slv_sda_valid(slv_sda_valid),
        .slv_setup_done(setup_done), .chan_req(chan_req), .chan_to_slave0(c0),
        .chan_to_slave1(c1), .reference_clock_input(ref_in), .rx_port0_on(rx_on[0]),
        .rx_port1_on(rx_on[1]), .rx_port2_on(rx_on[2]), .rx_port3_on(rx_on[3]));
    i2cm_bus_slave u_slave (.mclk(mclk), .scl_oe(scl_oe), .stall_cyc(stall_cyc),
        .scl_wire(scl_in));

    initial begin
        mclk = 1'b0;
        forever #10 mclk = ~mclk;
    end

    // ----------------------------------------
    // Check, bus and wait tasks
    // ----------------------------------------
    task chk(input [31:0] got, input [31:0] exp);
        begin
            n_tests = n_tests + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask

    task apb(input w, input [7:0] a, input [31:0] d, input [32:0] e);
        begin
            expq.push_back({w, e});
            psel <= 1'b1;
            penable <= 1'b0;
            pwrite <= w;
            paddr <= a;
            pwdata <= d;
            @(posedge mclk);
            penable <= 1'b1;
            @(posedge mclk);
            while (pready !== 1'b1)
                @(posedge mclk);
            psel <= 1'b0;
            penable <= 1'b0;
            @(posedge mclk);
        end
    endtask

    // Waits for n pulses of rise (sel 0) or setup done (sel 1)
    task wait_evt(input integer n, input sel);
        integer k;
        begin
            k = 0;
            while (k < n) begin
                @(posedge mclk);
                if ((sel ? setup_done : scl_rise) === 1'b1)
                    k = k + 1;
            end
        end
    endtask

    task end_of_test;
        begin
            $display("checks=%0d errors=%0d", n_tests, n_errors);
            if (n_errors == 0 && n_tests > 0)
                $display("Regression OK");
            else
                $display("Regression broken");
            $finish;
        end
    endtask

    // Response monitor takes the oldest note per completed transfer
    always @(posedge mclk) begin
        if (psel && penable && pready === 1'b1) begin
            chk({31'h0, pslverr}, {31'h0, expq[0][32]});
            if (!expq[0][33])
                chk(prdata, expq[0][31:0]);
            void'(expq.pop_front());
        end
    end

    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (cyc == 60000) begin
            n_errors = n_errors + 1;
            end_of_test;
        end
    end

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        seed = 32'hDB65;
        n_errors = 0;
        n_tests = 0;
        cyc = 0;
        rstn = 1'b0;
        {psel, penable, pwrite, paddr, pwdata} = 0;
        {mst_clk_req, slv_stretch, slv_sda_valid, ref_in} = 4'h0;
        chan_req = 4'h0;
        stall_cyc = 4'h0;
        repeat (12) @(posedge mclk);
        rstn <= 1'b1;
        repeat (3) @(posedge mclk);
        apb(1'b0, 8'h28, 32'h0, {1'b0, 32'h7A});
        apb(1'b0, 8'h2C, 32'h0, {1'b0, 32'h7A});
        apb(1'b0, 8'h30, 32'h0, {1'b0, 32'h0F});
        chk({28'h0, rx_on}, 32'hF);
        apb(1'b0, 8'h34, 32'h0, {1'b1, 32'h0});
        apb(1'b0, 8'h29, 32'h0, {1'b1, 32'h0});
        apb(1'b1, 8'h80, 32'hFF, {1'b1, 32'h0});
        ref_in <= 1'b1;
        apb(1'b0, 8'h80, 32'h0, {1'b0, 32'hD1});
        for (i = 0; i < 6; i = i + 1) begin
            ctl = (i < 2) ? (i ? 8'h0F : 8'hF0) : $random(seed);
            apb(1'b1, 8'h30, {24'h0, ctl}, 33'h0);
            apb(1'b0, 8'h30, 32'h0, {1'b0, 24'h0, ctl});
            chan_req <= $random(seed);
            repeat (2) @(posedge mclk);
            chk({28'h0, c0}, {28'h0, chan_req & ~ctl[7:4]});
            chk({28'h0, c1}, {28'h0, chan_req & ctl[7:4]});
            chk({28'h0, rx_on}, {28'h0, ctl[3:0]});
        end
        // Default counts first, then a zero, a random and a full count
        for (i = 0; i < 4; i = i + 1) begin
            stall_cyc <= i * 3;
            if (i > 0)
                apb(1'b1, 8'h28, (i == 3) ? 32'hFF : $random(seed) & 32'hF, 33'h0);
            if (i > 0)
                apb(1'b1, 8'h2C, (i == 1) ? 32'h0 : $random(seed) & 32'hFF, 33'h0);
            mst_clk_req <= 1'b1;
            wait_evt(3, 1'b0);
            mst_clk_req <= 1'b0;
            repeat (600) @(posedge mclk);
            slv_sda_valid <= 1'b1;
            @(posedge mclk);
            slv_sda_valid <= 1'b0;
            wait_evt(1, 1'b1);
        end
        slv_stretch <= 1'b1;
        repeat (4) @(posedge mclk);
        chk({31'h0, scl_in}, 32'h0);
        slv_stretch <= 1'b0;
        repeat (20) @(posedge mclk);
        chk({31'h0, scl_in}, 32'h1);
        end_of_test;
    end
endmodule

bind i2cm_top i2cm_props u_props (.*);
